// File: dv/scwr_host.sv
// Host model driving the two-wire link.
// Lines idle high as if pulled up; clock stands still between frames.
`timescale 1ns/1ps
module scwr_host #(parameter real HALF_NS = 62.5) (
	output logic sclk_o,
	output logic sdata_o
);
	// Idle level of both lines
	initial begin
		sclk_o = 1'b1;
		sdata_o = 1'b1;
	end
	// One frame: start, 88 bits, stop
	task automatic frame(input logic [87:0] bits);
		sdata_o = 1'b0; // Start
		#(HALF_NS);
		for (int i = 87; i >= 0; i--) begin
			sclk_o = 1'b0;
			#(HALF_NS / 2);
			sdata_o = bits[i]; // Bit 87 first, most significant bit of each byte leading
			#(HALF_NS / 2);
			sclk_o = 1'b1;
			#(HALF_NS);
		end
		sclk_o = 1'b0;
		#(HALF_NS / 2);
		sdata_o = 1'b0;
		#(HALF_NS / 2);
		sclk_o = 1'b1;
		#(HALF_NS / 2);
		sdata_o = 1'b1; // Stop
		#(HALF_NS);
	endtask
endmodule

// File: dv/scwr_top_chk.sv
// Port checker for the receiver top.
// Assumes one clock domain on CLK_I.
`timescale 1ns/1ps
module scwr_top_chk (
	input wire CLK_I,
	input wire RST_N_I,
	input wire SCLK_I,
	input wire SDATA_I,
	input wire CFG_HOLD_I,
	input wire SDATA_O,
	input wire SDATA_OE_O,
	input wire [63:0] CFG_O,
	input wire FRAME_BUSY_O,
	input wire ADDR_HIT_O,
	input wire OVERRUN_O
);
	localparam logic [63:0] DEF = 64'h0000_3000_0000_0000;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// Start marker seen on the raw lines
	sequence s_start;
		SCLK_I && $fell(SDATA_I);
	endsequence
	a_link_write_only: assert property (!SDATA_OE_O && !SDATA_O)
		else $error("link driven");
	a_cfg_defaults: assert property (disable iff (1'b0) !RST_N_I |=> CFG_O == DEF)
		else $error("bad default");
	a_miss_keeps_cfg: assert property (!ADDR_HIT_O |=> $stable(CFG_O))
		else $error("load on miss");
	a_load_needs_hit: assert property ($changed(CFG_O) |-> ADDR_HIT_O)
		else $error("load without hit");
	a_hit_in_frame: assert property ($changed(ADDR_HIT_O) |-> FRAME_BUSY_O)
		else $error("hit outside frame");
	a_hit_holds: assert property ($changed(ADDR_HIT_O) |=> $stable(ADDR_HIT_O) [*8])
		else $error("hit unstable");
	a_start_opens: assert property (s_start |-> ##[2:8] FRAME_BUSY_O)
		else $error("frame not opened");
endmodule
bind scwr_top scwr_top_chk u_chk (.*);

// File: dv/test_serial_config_write_receiver.sv
// Self-checking bench for the receiver.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module test_serial_config_write_receiver;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hold_i = 1'b0;
	wire sclk, sdata, sdo, sdo_oe, busy, hit, ovr;
	wire [63:0] cfg;
	int n_fail = 0;
	int num_checks = 0;
	localparam logic [63:0] DEF = 64'h0000_3000_0000_0000;
	localparam logic [63:0] VAL_A = 64'h0000_A05C_0000_0000; // Reserved bits zero
	localparam logic [63:0] VAL_B = 64'h0000_50A3_0000_0000; // Reserved bits zero
	always #2.5 clk_i = ~clk_i;
	scwr_host host (.sclk_o(sclk), .sdata_o(sdata));
	scwr_top dut (.CLK_I(clk_i), .RST_N_I(rst_n_i), .SCLK_I(sclk), .SDATA_I(sdata),
		.CFG_HOLD_I(hold_i), .SDATA_O(sdo), .SDATA_OE_O(sdo_oe), .CFG_O(cfg),
		.FRAME_BUSY_O(busy), .ADDR_HIT_O(hit), .OVERRUN_O(ovr));
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Frame: address, two ignored header bytes, data 0..7; link moves off the clock edge
	task automatic send(input logic [7:0] addr, input logic [63:0] val, input logic [15:0] hdr);
		logic [87:0] f;
		f = {addr, hdr, 64'h0};
		for (int k = 0; k < 8; k++)
			f[63 - 8 * k -: 8] = val[8 * k +: 8];
		@(posedge clk_i);
		#1;
		host.frame(f);
		repeat (20) @(posedge clk_i);
		#1;
	endtask
	task automatic t_reset();
		check(cfg, DEF);
		check({sdo, sdo_oe, busy, hit, ovr}, 64'h0);
	endtask
	task automatic t_match();
		send(8'hD2, VAL_A, 16'hA508);
		check(cfg, VAL_A);
		check(hit, 64'h1);
		send(8'hD2, VAL_B, 16'h5AF7);
		check(cfg, VAL_B);
	endtask
	task automatic t_miss();
		logic [7:0] bad [3] = '{8'h4B, 8'hD3, 8'h52};
		foreach (bad[i]) begin
			send(bad[i], VAL_A, 16'hA508);
			check(cfg, VAL_B);
			check(hit, 64'h0);
		end
	endtask
	// Stalled drain: config holds, fifth frame overflows and all but its first byte is dropped, four drain in order
	task automatic t_buffer();
		@(posedge clk_i);
		#1 hold_i = 1'b1;
		send(8'hD2, VAL_A, 16'hA508);
		check(cfg, VAL_B);
		repeat (3) send(8'hD2, VAL_A, 16'hA508);
		send(8'hD2, VAL_B, 16'hA508);
		check(ovr, 64'h1);
		@(posedge clk_i);
		#1 hold_i = 1'b0;
		repeat (100) @(posedge clk_i);
		#1;
		check(busy, 64'h0);
		check(cfg, VAL_A);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		t_reset();
		t_match();
		t_miss();
		t_buffer();
		final_report();
	end
	// Watchdog well past ten frames
	initial begin
		#300000;
		n_fail++;
		final_report();
	end
endmodule

// File: hdl/scwr_top.v
// Serial configuration write receiver: samples the host link, assembles
// bytes, buffers them in a FIFO, and loads eight configuration bytes.
// Assumes a host clock far slower than CLK_I and idle-high link lines.
`timescale 1ns/1ps
`include "scwr_map.vh"

module scwr_fifo #(
	parameter WIDTH = `SCWR_FIFO_WIDTH,
	parameter DEPTH = `SCWR_FIFO_DEPTH,
	parameter AW = `SCWR_FIFO_AW
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [WIDTH-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	output reg [WIDTH-1:0] out_data_o,
	output reg out_valid_o,
	input wire out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr_r;
	reg [AW:0] rd_ptr_r;
	wire full_w;
	wire empty_w;
	wire push_w;
	wire pop_w;

	// Honest full and empty from wrap-bit pointers
	assign full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty_w = (wr_ptr_r == rd_ptr_r);
	assign in_ready_o = ~full_w;
	assign push_w = in_valid_i & ~full_w;
	assign pop_w = ~empty_w & (~out_valid_o | out_ready_i);

	// Storage write
	always @(posedge clk_i) begin
		if (push_w) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data_i;
		end
	end

	// Pointers and registered output stage
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
			out_data_o <= {WIDTH{1'b0}};
			out_valid_o <= 1'b0;
		end else begin
			if (push_w) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop_w) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
				out_data_o <= mem[rd_ptr_r[AW-1:0]];
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
		end
	end
endmodule

module scwr_top (
	input wire CLK_I,
	input wire RST_N_I,
	input wire SCLK_I,
	input wire SDATA_I,
	input wire CFG_HOLD_I,
	output wire SDATA_O,
	output wire SDATA_OE_O,
	output reg [63:0] CFG_O,
	output reg FRAME_BUSY_O,
	output reg ADDR_HIT_O,
	output reg OVERRUN_O
);
	reg sclk_s1_r;
	reg sclk_s2_r;
	reg sclk_d_r;
	reg sda_s1_r;
	reg sda_s2_r;
	reg sda_d_r;
	reg [7:0] shift_r;
	reg [2:0] bit_cnt_r;
	reg [7:0] push_data_r;
	reg push_valid_r;
	reg [3:0] pos_r;
	reg [3:0] pos_nxt;
	reg match_r;
	reg in_frame_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	wire sclk_rise_w;
	wire start_w;
	wire stop_w;
	wire fifo_ready_w;
	wire [7:0] pop_data_w;
	wire pop_valid_w;
	wire pop_ready_w;
	wire [8:0] push_word_w;
	wire [8:0] pop_word_w;

	localparam ST_IDLE = 3'b001;
	localparam ST_BYTE = 3'b010;
	localparam ST_SKIP = 3'b100;

	// Own-address decode, shared by the frame state and the hit flag
	function addr_is_own(input [7:0] b_in);
		addr_is_own = (b_in == `SCWR_OWN_ADDR);
	endfunction

	// Link is input only toward the device
	assign SDATA_O = 1'b0;
	assign SDATA_OE_O = 1'b0;

	// Two-stage synchronisers, then a delay stage for edge detection
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sclk_s1_r <= 1'b1;
			sclk_s2_r <= 1'b1;
			sclk_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			sclk_s1_r <= SCLK_I;
			sclk_s2_r <= sclk_s1_r;
			sclk_d_r <= sclk_s2_r;
			sda_s1_r <= SDATA_I;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
		end
	end

	// Frame markers: data falls or rises while the clock is high
	assign sclk_rise_w = sclk_s2_r & ~sclk_d_r;
	assign start_w = sclk_s2_r & sclk_d_r & sda_d_r & ~sda_s2_r;
	assign stop_w = sclk_s2_r & sclk_d_r & ~sda_d_r & sda_s2_r;

	// Frame state: collecting bytes or skipping a foreign transfer
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_w) begin
					state_nxt = ST_BYTE;
				end
			end
			ST_BYTE: begin
				if (stop_w) begin
					state_nxt = ST_IDLE;
				end else if (push_valid_r && pos_r == 4'h0 && !addr_is_own(push_data_r)) begin
					state_nxt = ST_SKIP;
				end
			end
			ST_SKIP: begin
				if (stop_w) begin
					state_nxt = ST_IDLE;
				end else if (start_w) begin
					state_nxt = ST_BYTE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Bit assembly, most significant bit first
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_r <= ST_IDLE;
			shift_r <= 8'h00;
			bit_cnt_r <= 3'h0;
			push_data_r <= 8'h00;
			push_valid_r <= 1'b0;
			FRAME_BUSY_O <= 1'b0;
		end else begin
			state_r <= state_nxt;
			push_valid_r <= 1'b0;
			FRAME_BUSY_O <= (state_nxt != ST_IDLE);
			if (start_w) begin
				bit_cnt_r <= 3'h0;
			end else if (sclk_rise_w && state_r == ST_BYTE) begin
				shift_r <= {shift_r[6:0], sda_s2_r};
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7) begin
					push_data_r <= {shift_r[6:0], sda_s2_r};
					push_valid_r <= 1'b1;
				end
			end
		end
	end

	// Byte position: every byte counts up to SCWR_BYTES_PER_FRAME, then holds, header included
	always @* begin
		pos_nxt = pos_r;
		if (start_w) begin
			pos_nxt = 4'h0;
		end else if (push_valid_r && pos_r != `SCWR_BYTES_PER_FRAME) begin
			pos_nxt = pos_r + 4'h1;
		end
	end

	// Address compare on the first byte
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pos_r <= 4'h0;
			match_r <= 1'b0;
			ADDR_HIT_O <= 1'b0;
			OVERRUN_O <= 1'b0;
		end else begin
			pos_r <= pos_nxt;
			if (start_w) begin
				match_r <= 1'b0;
			end else if (push_valid_r && pos_r == 4'h0) begin
				match_r <= addr_is_own(push_data_r);
				ADDR_HIT_O <= addr_is_own(push_data_r);
			end
			if (push_valid_r && !fifo_ready_w) begin
				OVERRUN_O <= 1'b1;
			end
		end
	end

	// Only data bytes of a matching frame enter the buffer, tagged with frame start
	assign push_word_w = {pos_r == `SCWR_FIRST_DATA_POS, push_data_r};

	scwr_fifo #(
		.WIDTH(9),
		.DEPTH(`SCWR_FIFO_DEPTH),
		.AW(`SCWR_FIFO_AW)
	) u_fifo (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.in_data_i(push_word_w),
		.in_valid_i(push_valid_r & match_r & (pos_r >= `SCWR_FIRST_DATA_POS)
			& (pos_r < `SCWR_BYTES_PER_FRAME)),
		.in_ready_o(fifo_ready_w),
		.out_data_o(pop_word_w),
		.out_valid_o(pop_valid_w),
		.out_ready_i(pop_ready_w)
	);

	assign pop_data_w = pop_word_w[7:0];
	assign pop_ready_w = ~CFG_HOLD_I;

	// Configuration bytes load in order, defaults at reset
	reg [2:0] load_idx_r;
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			load_idx_r <= 3'h0;
			CFG_O <= {`SCWR_DEF_BYTE7, `SCWR_DEF_BYTE6, `SCWR_DEF_BYTE5, `SCWR_DEF_BYTE4,
				`SCWR_DEF_BYTE3, `SCWR_DEF_BYTE2, `SCWR_DEF_BYTE1, `SCWR_DEF_BYTE0};
		end else if (pop_valid_w && pop_ready_w) begin
			// Stored as received, reserved bits included
			if (pop_word_w[8]) begin
				CFG_O[7:0] <= pop_data_w;
				load_idx_r <= 3'h1;
			end else begin
				CFG_O[load_idx_r*8 +: 8] <= pop_data_w;
				load_idx_r <= load_idx_r + 3'h1;
			end
		end
	end
endmodule

// File: shared/scwr_map.vh
// Constants for the serial configuration write receiver.
// Assumes inclusion by bare name from the design files.
`ifndef SCWR_MAP_VH
`define SCWR_MAP_VH
`define SCWR_OWN_ADDR 8'hD2
`define SCWR_BYTES_PER_FRAME 4'hB
`define SCWR_FIRST_DATA_POS 4'h3
`define SCWR_DEF_BYTE0 8'h00
`define SCWR_DEF_BYTE1 8'h00
`define SCWR_DEF_BYTE2 8'h00
`define SCWR_DEF_BYTE3 8'h00
`define SCWR_DEF_BYTE4 8'h00
`define SCWR_DEF_BYTE5 8'h30
`define SCWR_DEF_BYTE6 8'h00
`define SCWR_DEF_BYTE7 8'h00
`define SCWR_FIFO_WIDTH 8
`define SCWR_FIFO_DEPTH 32
`define SCWR_FIFO_AW 5
`endif
